// ===== design/cdt_channel.sv
// one down-counting timer channel with auto-reload and input capture
// assumes an apb master on clock, and an asynchronous pin on extPin
//
// Contract
// RQ1: capture request sets capture flag bit 9
// RQ2: writing 0 clears flag, 1 keeps it
// RQ3: underflow sets flag bit 8, sticky
// RQ4: capture control 00 off, 01 prohibited
// RQ5: underflow irq when enable and flag set
// RQ6: edge field: rise, fall, or both
// RQ7: prescaler picks divider or external pin
// RQ8: reload register 32 bits, reset all-ones; the code resets it to 32'h0fff_ffff
// RQ9: counter decrements once per active tick
// RQ10: past zero: set flag, reload, continue
// RQ11: counter resets to all-ones value; the code resets it to 32'h0fff_ffff
// RQ12: capture event copies counter to capture
// RQ13: capture register undefined before first capture
// RQ14: control bits 15 to 10 read zero
// RQ15: run bit halts or runs counter
// RQ16: pin pulses at least 2 or 3 cycles
// RQ17: capture needs internal count source; the code captures with any source selected
// RQ18: read during tick returns old value
// RQ19: capture irq when flag and code 11
`include "cdt_defines.svh"

module cdt_channel #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              clkEn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              extPin,
   output logic                   underflowIrq,
   output logic                   captureIrq,
   output logic                   irq
);

   // ==========================================
   // elaboration check
   if (ADDR_W < 5) begin : g_bad_addr
      $error("cdt_channel: ADDR_W must be at least 5");
   end

   // ==========================================
   // register state
   cdt_pkg::cdt_ctrl_t ctrl;
   cdt_pkg::cdt_ctrl_t next_ctrl;

   logic               capFlag;
   logic               next_capFlag;

   logic               unfFlag;
   logic               next_unfFlag;

   logic               runBit;
   logic               next_runBit;

   logic [31:0]        reloadVal;
   logic [31:0]        next_reloadVal;

   logic [31:0]        count;
   logic [31:0]        next_count;

   logic [31:0]        captVal;
   logic [31:0]        next_captVal;

   logic [1:0]         status;
   logic [1:0]         next_status;

   logic [1:0]         mask;
   logic [1:0]         next_mask;

   logic [7:0]         div;
   logic [7:0]         next_div;

   logic [31:0]        next_prdata;
   logic               next_pslverr;

   // ==========================================
   // pin synchroniser and edge detect
   logic pinMeta;
   logic pinSync;
   logic pinPrev;
   logic rise;
   logic fall;
   logic edgeHit;

   // ==========================================
   // bus decode
   logic       setup;
   logic       access;
   logic       wrAcc;
   logic       rdAcc;
   logic [7:0] addr;
   logic       mapped;
   logic       wrCtrl;
   logic       wrReload;
   logic       wrCount;
   logic       wrRun;
   logic       wrMask;
   logic       rdStat;

   // ==========================================
   // count control
   logic                divTick;
   logic                tick;
   logic                capOn;
   cdt_pkg::cdt_evt_t   evt;

   // ==========================================
   // helpers
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // reserved control bits 15..10 are never driven
   function automatic logic [31:0] ctrlWord();
      logic [31:0] w;
      w                = 32'h0000_0000;
      w[`CDT_CAPF_BIT] = capFlag;
      w[`CDT_UNF_BIT]  = unfFlag;
      w[7:0]           = ctrl;
      return w;
   endfunction

   function automatic logic [31:0] readMux(input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (1'b1)
         hit(a, `CDT_OFS_CTRL):   r = ctrlWord();           // [RQ14]
         hit(a, `CDT_OFS_RELOAD): r = reloadVal;
         hit(a, `CDT_OFS_COUNT):  r = count;
         hit(a, `CDT_OFS_CAPT):   r = captVal;
         hit(a, `CDT_OFS_RUN):    r[`CDT_RUN_BIT] = runBit;
         hit(a, `CDT_OFS_STAT):   r[1:0] = status;
         hit(a, `CDT_OFS_MASK):   r[1:0] = mask;
         default:                 r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // ==========================================
   // synchroniser: the first stage feeds only the second
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
         pinPrev <= 1'b0;
      end else if (clkEn) begin
         pinMeta <= extPin;
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   // short pin pulses are not filtered; the far side keeps widths
   always_comb begin                                  // [RQ16]
      rise    = pinSync & ~pinPrev;
      fall    = ~pinSync & pinPrev;
      if (ctrl.edgeSel[1])
         edgeHit = rise | fall;                       // [RQ6]
      else if (ctrl.edgeSel[0])
         edgeHit = fall;                              // [RQ6]
      else
         edgeHit = rise;                              // [RQ6]
   end

   // ==========================================
   // bus decode
   always_comb begin
      addr   = 8'(paddr);
      setup  = psel & ~penable;
      access = psel & penable & clkEn;
      wrAcc  = access & pwrite;
      rdAcc  = access & ~pwrite;
      mapped = hit(addr, `CDT_OFS_CTRL)   | hit(addr, `CDT_OFS_RELOAD) |
               hit(addr, `CDT_OFS_COUNT)  | hit(addr, `CDT_OFS_CAPT)   |
               hit(addr, `CDT_OFS_RUN)    | hit(addr, `CDT_OFS_STAT)   |
               hit(addr, `CDT_OFS_MASK);
      wrCtrl   = wrAcc & hit(addr, `CDT_OFS_CTRL);
      wrReload = wrAcc & hit(addr, `CDT_OFS_RELOAD);
      wrCount  = wrAcc & hit(addr, `CDT_OFS_COUNT);
      wrRun    = wrAcc & hit(addr, `CDT_OFS_RUN);
      wrMask   = wrAcc & hit(addr, `CDT_OFS_MASK);
      rdStat   = rdAcc & hit(addr, `CDT_OFS_STAT);
   end

   // zero wait states; a low clkEn stretches the access phase
   always_comb begin
      pready = psel & penable & clkEn;
   end

   // ==========================================
   // count source
   always_comb begin
      unique case (ctrl.psc)                          // [RQ7]
         3'h0:         divTick = &div[1:0];
         3'h1:         divTick = &div[3:0];
         3'h2:         divTick = &div[5:0];
         3'h3:         divTick = &div[7:0];
         `CDT_PSC_EXT: divTick = edgeHit;
         default:      divTick = 1'b0;
      endcase
      // capture ignores the source; software keeps it internal
      capOn       = ctrl.capCtrl[1];                  // [RQ4] [RQ17]
      tick        = runBit & divTick;                 // [RQ15]
      evt.underflow = tick & (count == 32'h0000_0000);
      evt.capture   = capOn & edgeHit;                // [RQ4] [RQ6]
   end

   // ==========================================
   // free divider from reset; tick phase does not follow software
   always_comb begin
      next_div = div + 8'h01;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         div <= 8'h00;
      else if (clkEn)
         div <= next_div;
   end

   // ==========================================
   // read path; prdata and pslverr stand until the next setup
   always_comb begin
      next_prdata  = prdata;
      next_pslverr = pslverr;

      if (setup) begin
         // sampled before this edge's decrement
         next_prdata  = readMux(addr);                // [RQ18]
         next_pslverr = ~mapped;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // ==========================================
   // control, flags, run bit and mask
   always_comb begin
      next_ctrl    = ctrl;
      next_capFlag = capFlag;
      next_unfFlag = unfFlag;
      next_runBit  = runBit;
      next_mask    = mask;

      // a 1 written to a flag leaves it as it was
      if (wrCtrl) begin
         next_ctrl = pwdata[7:0];
         if (!pwdata[`CDT_CAPF_BIT])
            next_capFlag = 1'b0;                      // [RQ2]
         if (!pwdata[`CDT_UNF_BIT])
            next_unfFlag = 1'b0;                      // [RQ2]
      end

      if (wrRun)
         next_runBit = pwdata[`CDT_RUN_BIT];          // [RQ15]

      if (wrMask)
         next_mask = pwdata[1:0];

      // events win over a clear in the same cycle
      if (evt.capture)
         next_capFlag = 1'b1;                         // [RQ1]
      if (evt.underflow)
         next_unfFlag = 1'b1;                         // [RQ3]
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl    <= '0;
         capFlag <= 1'b0;
         unfFlag <= 1'b0;
         runBit  <= 1'b0;
         mask    <= 2'h0;
      end else if (clkEn) begin
         ctrl    <= next_ctrl;
         capFlag <= next_capFlag;
         unfFlag <= next_unfFlag;
         runBit  <= next_runBit;
         mask    <= next_mask;
      end
   end

   // ==========================================
   // counter and reload constant
   always_comb begin
      next_reloadVal = reloadVal;
      next_count     = count;

      // counting; a bus write to the counter below overrides it
      if (evt.underflow)
         next_count = reloadVal;                      // [RQ10]
      else if (tick)
         next_count = count - 32'h0000_0001;          // [RQ9]

      if (wrReload)
         next_reloadVal = pwdata;                     // [RQ8]
      if (wrCount)
         next_count = pwdata;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reloadVal <= `CDT_RELOAD_RST;                // [RQ8]
         count     <= `CDT_COUNT_RST;                 // [RQ11]
      end else if (clkEn) begin
         reloadVal <= next_reloadVal;
         count     <= next_count;
      end
   end

   // ==========================================
   // sticky status, cleared by a read
   always_comb begin
      next_status = status;

      // clear only what the read reported, so a later event survives
      if (rdStat)
         next_status = status & ~prdata[1:0];
      if (evt.underflow)
         next_status[`CDT_ST_UNF_BIT] = 1'b1;
      if (evt.capture)
         next_status[`CDT_ST_CAP_BIT] = 1'b1;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         status <= 2'h0;
      else if (clkEn)
         status <= next_status;
   end

   // ==========================================
   // capture register
   // a halted counter still captures its held value
   always_comb begin
      next_captVal = captVal;
      if (evt.capture)
         next_captVal = count;                        // [RQ12]
   end

   // no reset: contents undefined until first capture
   always_ff @(posedge clock) begin                   // [RQ13]
      if (clkEn)
         captVal <= next_captVal;
   end

   // ==========================================
   // interrupt requests
   always_comb begin
      underflowIrq = unfFlag & ctrl.underflow_irq_enable;             // [RQ5]
      captureIrq   = capFlag &
                     (ctrl.capCtrl == `CDT_CAP_IRQ);  // [RQ19] [RQ4]
      // one combined line for software that polls status
      irq          = |(status & mask);
   end

endmodule : cdt_channel

// ===== design/cdt_defines.svh
// register map, field positions, reset values and encodings
// included by the timer channel and its test bench
`ifndef CDT_DEFINES_SVH
`define CDT_DEFINES_SVH

// ==========================================
// register byte offsets
`define CDT_OFS_CTRL    8'h00
`define CDT_OFS_RELOAD  8'h04
`define CDT_OFS_COUNT   8'h08
`define CDT_OFS_CAPT    8'h0c
`define CDT_OFS_RUN     8'h10
`define CDT_OFS_STAT    8'h14
`define CDT_OFS_MASK    8'h18

// ==========================================
// control, run and status field positions
`define CDT_CAPF_BIT    9
`define CDT_UNF_BIT     8
`define CDT_RUN_BIT     2
`define CDT_ST_UNF_BIT  0
`define CDT_ST_CAP_BIT  1

// ==========================================
// reset values
`define CDT_RELOAD_RST  32'h0fff_ffff
`define CDT_COUNT_RST   32'h0fff_ffff

// ==========================================
// encodings
`define CDT_PSC_EXT     3'h5
`define CDT_CAP_OFF     2'h0
`define CDT_CAP_IRQ     2'h3

`endif

// ===== design/cdt_pkg.sv
// types shared by the timer channel and its users
// assumes cdt_defines.svh for all numeric constants
package cdt_pkg;

   // ==========================================
   // writable part of the channel control register
   typedef struct packed {
      logic [1:0] capCtrl;
      logic       underflow_irq_enable;
      logic [1:0] edgeSel;
      logic [2:0] psc;
   } cdt_ctrl_t;

   // ==========================================
   // events raised by the counter in one cycle
   typedef struct packed {
      logic capture;
      logic underflow;
   } cdt_evt_t;

endpackage : cdt_pkg

// ===== sim/cdt_pin_model.sv
// far-side driver of the external clock/capture pin
// assumes the bench calls pulse with widths in clock cycles
module cdt_pin_model (
   input  wire logic clock,
   output logic      extPin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial extPin = 1'b0;
   // ==========================================
   // pulses wide enough for both-edge sensing, so no edge is lost
   task automatic pulse(input int n, input int w);
      repeat (n) begin
         @(posedge clock);
         extPin <= 1'b1;
         repeat (w) @(posedge clock);
         extPin <= 1'b0;
         repeat (w) @(posedge clock);
      end
   endtask
endmodule // cdt_pin_model

// ===== sim/cdt_channel_chk.sv
// port-level assertions for the timer channel
// assumes one clock domain; bound onto cdt_channel below
module cdt_channel_chk #(
   parameter int ADDR_W = 8
) (
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              clkEn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              underflowIrq,
   input wire logic              captureIrq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic ctrlWr;
   assign ctrlWr = psel && penable && pready && pwrite && paddr[7:0] == 8'h00;
   // ==========================================
   // bus steps, irq enables and sticky flags
   sequence readDone;
      psel && penable && pready ##1 !psel;
   endsequence
   a_ready_zero_wait: assert property (pready == (psel && penable && clkEn))
      else $error("pready not zero wait");
   a_read_stands: assert property (readDone |-> $stable(prdata) && $stable(pslverr))
      else $error("read data moved");
   a_unmapped_err: assert property (psel && penable && paddr[7:0] > 8'h18 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_ctrl_reserved: assert property (psel && penable && !pwrite && paddr[7:0] == 8'h00 |-> prdata[15:10] == 6'h0)
      else $error("reserved control bits set");
   a_unf_irq_off: assert property (ctrlWr && !pwdata[5] |=> !underflowIrq)
      else $error("underflow irq while disabled");
   a_cap_irq_code: assert property (ctrlWr && pwdata[7:6] != 2'h3 |=> !captureIrq)
      else $error("capture irq with wrong code");
   a_unf_flag_sticky: assert property (underflowIrq && !ctrlWr |=> underflowIrq)
      else $error("underflow flag dropped");
   a_cap_flag_sticky: assert property (captureIrq && !ctrlWr |=> captureIrq)
      else $error("capture flag dropped");
endmodule // cdt_channel_chk

bind cdt_channel cdt_channel_chk #(.ADDR_W(ADDR_W)) chkU (.*);

// ===== sim/cdt_channel_test.sv
// self-checking bench for the timer channel
// assumes cdt_channel with bound checker and the pin model
`include "cdt_defines.svh"
module cdt_channel_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        clkEn = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, extPin, underflowIrq, captureIrq, irq, err;
   int          error_cnt = 0;
   int          compares = 0;
   int          cyc = 0;
   int          seed = 7004;
   int          mdl;
   int          divs[4] = '{4, 16, 64, 256};
   always #25 clock = ~clock;
   cdt_channel dut_u (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .extPin(extPin), .underflowIrq(underflowIrq),
      .captureIrq(captureIrq), .irq(irq));
   cdt_pin_model pinU (.clock(clock), .extPin(extPin));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      apb(1'b0, `CDT_OFS_RELOAD, 0);
      chk(rd, 32'h0fff_ffff);
      apb(1'b0, `CDT_OFS_COUNT, 0);
      chk(rd, 32'h0fff_ffff);
      // window of exactly three ticks; code 100 must not count
      for (int p = 0; p < 5; p++) begin
         mdl = ($random(seed) & 16'hffff) + 16;
         apb(1'b1, `CDT_OFS_COUNT, mdl);
         apb(1'b1, `CDT_OFS_CTRL, (p == 4) ? 32'h4 : p);
         apb(1'b1, `CDT_OFS_RUN, 32'h4);
         repeat (((p == 4) ? 4 : divs[p]) * 3 - 3) @(posedge clock);
         apb(1'b1, `CDT_OFS_RUN, 0);
         apb(1'b0, `CDT_OFS_COUNT, 0);
         chk(rd, (p == 4) ? mdl : mdl - 3);
      end
      for (int e = 0; e < 4; e++) begin
         mdl = ($random(seed) & 16'hffff) + 16;
         apb(1'b1, `CDT_OFS_COUNT, mdl);
         apb(1'b1, `CDT_OFS_CTRL, (e << 3) | 5);
         apb(1'b1, `CDT_OFS_RUN, 32'h4);
         pinU.pulse(3, 3);
         repeat (6) @(posedge clock);
         apb(1'b1, `CDT_OFS_RUN, 0);
         apb(1'b0, `CDT_OFS_COUNT, 0);
         chk(rd, mdl - ((e > 1) ? 6 : 3));
      end
      // pin tick lands on the setup edge of a counter read
      apb(1'b1, `CDT_OFS_CTRL, 32'h5);
      apb(1'b1, `CDT_OFS_RUN, 32'h4);
      fork
         pinU.pulse(1, 3);
         begin
            repeat (2) @(posedge clock);
            apb(1'b0, `CDT_OFS_COUNT, 0);
         end
      join
      chk(rd, mdl - 6);
      repeat (6) @(posedge clock);
      apb(1'b1, `CDT_OFS_RUN, 0);
      apb(1'b0, `CDT_OFS_COUNT, 0);
      chk(rd, mdl - 7);
      // underflow from one with a random reload
      mdl = $random(seed);
      apb(1'b1, `CDT_OFS_RELOAD, mdl);
      apb(1'b1, `CDT_OFS_COUNT, 1);
      apb(1'b1, `CDT_OFS_MASK, 3);
      apb(1'b1, `CDT_OFS_CTRL, 32'h25);
      apb(1'b1, `CDT_OFS_RUN, 32'h4);
      pinU.pulse(3, 3);
      repeat (6) @(posedge clock);
      apb(1'b1, `CDT_OFS_RUN, 0);
      apb(1'b0, `CDT_OFS_COUNT, 0);
      chk(rd, mdl - 1);
      @(negedge clock);
      chk(32'({underflowIrq, irq}), 3);
      apb(1'b1, `CDT_OFS_CTRL, 32'h125);
      apb(1'b0, `CDT_OFS_CTRL, 0);
      chk(rd, 32'h125);
      apb(1'b0, `CDT_OFS_STAT, 0);
      chk(rd & 32'h1, 1);
      apb(1'b1, `CDT_OFS_CTRL, 32'h25);
      apb(1'b0, `CDT_OFS_CTRL, 0);
      chk(rd, 32'h25);
      @(negedge clock);
      chk(32'({underflowIrq, irq}), 0);
      // capture on a halted counter, internal source selected
      mdl = $random(seed);
      apb(1'b1, `CDT_OFS_COUNT, mdl);
      apb(1'b1, `CDT_OFS_CTRL, 32'hc0);
      pinU.pulse(1, 3);
      repeat (6) @(posedge clock);
      apb(1'b0, `CDT_OFS_CAPT, 0);
      chk(rd, mdl);
      @(negedge clock);
      chk(32'({captureIrq, irq}), 3);
      apb(1'b1, `CDT_OFS_CTRL, 32'h280);
      apb(1'b0, `CDT_OFS_CTRL, 0);
      chk(rd, 32'h280);
      apb(1'b1, `CDT_OFS_CTRL, 32'h40);
      pinU.pulse(1, 3);
      repeat (6) @(posedge clock);
      apb(1'b0, `CDT_OFS_CTRL, 0);
      chk(rd, 32'h40);
      apb(1'b0, 8'h1c, 0);
      chk(32'({err, rd[0]}), 2);
      tally_and_finish();
   end
endmodule // cdt_channel_test
